//--- verilog/sel_power_defs.svh
// Offsets, fields, reset values and timing counts for interface selection
`ifndef SEL_POWER_DEFS_SVH
`define SEL_POWER_DEFS_SVH
`define DEV_STATUS_ADDR 8'h11
`define DEV_CTRL_ADDR   8'h12
`define DEV_CTRL_RST    8'h00
`define CTRL_OVR_BIT    7
`define CTRL_CHOICE_BIT 6
`define CTRL_PWR_BIT    0
`define STAT_ANA_HI     7
`define STAT_ANA_LO     5
`define STAT_DCLK_BIT   4
`define FRAME_BITS      5'd17
`define ADDR_DONE_BIT   5'd8
`define LAST_BIT        5'd16
`define SER_HALF_CYC    8
`define POLL_CYC        1000
`define CLK_PERIOD_NS   40
`define HPD_PULSE_NS    1000
`define HPD_CYC         (`HPD_PULSE_NS / `CLK_PERIOD_NS)
`define C_CTRL_OFS      5'h00
`define C_STAT_OFS      5'h04
`define C_INT_OFS       5'h08
`define C_MASK_OFS      5'h0c
`define C_CTRL_RST      3'h5
`define C_AUTO_BIT      0
`define C_PREF_BIT      1
`define C_HPEN_BIT      2
`define INT_SEL_BIT     0
`define INT_PD_BIT      1
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

//--- verilog/sel_power_pkg.sv
// Types shared by both ends of the interface selection link
`default_nettype none
package sel_power_pkg;
	typedef enum logic [1:0] {
		IF_NONE    = 2'b00,
		IF_ANALOG  = 2'b01,
		IF_DIGITAL = 2'b10
	} iface_t;
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_START = 3'b001,
		S_LOW   = 3'b010,
		S_HIGH  = 3'b011,
		S_P1    = 3'b100,
		S_P2    = 3'b101,
		S_P3    = 3'b110
	} ser_state_t;
	typedef enum logic [1:0] {
		C_WAIT  = 2'b00,
		C_READ  = 2'b01,
		C_WRITE = 2'b10
	} ctl_state_t;
endpackage
`default_nettype wire

//--- verilog/serial_reg_if.sv
// Two-wire serial register port between controller and device
`default_nettype none
interface serial_reg_if;
	logic scl;
	logic sda_m_oe;
	logic sda_s_oe;
	logic sda;
	// Open drain: any enable pulls the line low
	assign sda = ~(sda_m_oe | sda_s_oe);
	modport ctrl (output scl, output sda_m_oe, input sda);
	modport dev (input scl, input sda, output sda_s_oe);
endinterface
`default_nettype wire

//--- verilog/sel_power_device.sv
// Device end: serial register slave and interface power control
`include "sel_power_defs.svh"
`default_nettype none
// Behaviour
// RULE_01: Override set selects interface by choice bit
// RULE_02: Power bit zero powers all down, sync low
// RULE_03: Controller ORs status bits 7:5 for analog
// RULE_04: Controller sets override, selects explicitly
// RULE_05: Controller takes digital activity from outside
// RULE_06: Controller decides priority when both active
// RULE_07: Inactive interface mostly powered down
// RULE_08: Hsync detector powered while digital active
// RULE_09: Shared sync, outputs, reference powered when active
// RULE_10: Serial port works even when powered down
// RULE_11: Controller powers down when nothing active
// RULE_12: Controller pulses hot-plug on analog-to-digital
// RULE_13: Control and status reached over serial port
// RULE_14: New setting applies at write end, holds
module sel_power_device (
	input  wire logic                core_clk_i,
	input  wire logic                rst_n_i,
	serial_reg_if.dev                bus,
	input  wire logic [2:0]          analog_act_i,
	input  wire logic                digital_clk_det_i,
	output var sel_power_pkg::iface_t active_iface_o,
	output logic                     analog_power_o,
	output logic                     digital_power_o,
	output logic                     hsync_det_power_o,
	output logic                     shared_power_o,
	output logic                     sync_present_pin_o,
	output logic [7:0]               ctrl_reg_o
);
	import sel_power_pkg::*;

	////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [5:0] raw;
	logic [5:0] s1_q;
	logic [5:0] s2_q;
	logic [5:0] s3_q;
	logic [5:0] filt_q;
	logic [5:0] agree;

	assign raw = {digital_clk_det_i, analog_act_i, bus.sda, bus.scl};
	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= 6'h03;
			s2_q <= 6'h03;
			s3_q <= 6'h03;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Change counts once second and third agree
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			filt_q <= 6'h03;
		end else begin
			filt_q <= (filt_q & ~agree) | (s3_q & agree);
		end
	end

	logic       scl_f;
	logic       sda_f;
	logic [2:0] ana_f;
	logic       dclk_f;
	logic       scl_p_q;
	logic       sda_p_q;

	assign scl_f = filt_q[0];
	assign sda_f = filt_q[1];
	assign ana_f = filt_q[4:2];
	assign dclk_f = filt_q[5];

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
		end
	end

	////////////////////////////////////////////////////////////////
	// Serial frame decode

	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;

	assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
	assign stop_det  = scl_f & scl_p_q & ~sda_p_q & sda_f;
	assign scl_rise  = scl_f & ~scl_p_q;
	assign scl_fall  = ~scl_f & scl_p_q;

	logic        frame_q;
	logic [4:0]  cnt_q;
	logic [15:0] sh_q;
	logic        rd_q;
	logic [7:0]  tx_q;
	logic        oe_q;
	logic [7:0]  ctrl_q;
	logic [7:0]  status_byte;
	logic [7:0]  addr_now;
	logic [7:0]  rd_val;
	logic        take_bit;

	assign status_byte = {ana_f, dclk_f, 4'h0};
	assign addr_now = {sh_q[6:0], sda_f};
	assign take_bit = scl_rise & frame_q & (cnt_q < `FRAME_BITS);

	always_comb begin
		if (addr_now == `DEV_STATUS_ADDR) begin
			rd_val = status_byte;
		end else if (addr_now == `DEV_CTRL_ADDR) begin
			rd_val = ctrl_q;
		end else begin
			rd_val = 8'h00;
		end
	end

	// RULE_10: Always-on frame tracking
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frame_q <= 1'b0;
			cnt_q   <= 5'h00;
		end else if (start_det) begin
			frame_q <= 1'b1;
			cnt_q   <= 5'h00;
		end else if (stop_det) begin
			frame_q <= 1'b0;
		end else if (take_bit) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sh_q <= 16'h0000;
		end else if (take_bit) begin
			sh_q <= {sh_q[14:0], sda_f};
		end
	end

	// RULE_13: Read data prepared after address
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_q <= 1'b0;
			tx_q <= 8'h00;
			oe_q <= 1'b0;
		end else if (start_det || stop_det) begin
			rd_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (take_bit && cnt_q == `ADDR_DONE_BIT) begin
			rd_q <= sh_q[7];
			tx_q <= rd_val;
		end else if (scl_fall) begin
			if (frame_q && rd_q && cnt_q > `ADDR_DONE_BIT
				&& cnt_q <= `LAST_BIT) begin
				oe_q <= ~tx_q[7];
				tx_q <= {tx_q[6:0], 1'b0};
			end else begin
				oe_q <= 1'b0;
			end
		end
	end

	assign bus.sda_s_oe = oe_q;

	// RULE_14: Commit on last data bit
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= `DEV_CTRL_RST;
		end else if (take_bit && cnt_q == `LAST_BIT && !sh_q[15]
			&& sh_q[14:7] == `DEV_CTRL_ADDR) begin
			ctrl_q <= {sh_q[6:0], sda_f};
		end
	end

	assign ctrl_reg_o = ctrl_q;

	////////////////////////////////////////////////////////////////
	// Interface selection and power

	iface_t iface;
	logic   ana_det;

	assign ana_det = |ana_f;

	always_comb begin
		// RULE_02: Power bit low forces none
		if (!ctrl_q[`CTRL_PWR_BIT]) begin
			iface = IF_NONE;
		// RULE_01: Override selects by choice
		end else if (ctrl_q[`CTRL_OVR_BIT]) begin
			iface = ctrl_q[`CTRL_CHOICE_BIT] ? IF_DIGITAL : IF_ANALOG;
		end else if (ana_det) begin
			iface = IF_ANALOG;
		end else if (dclk_f) begin
			iface = IF_DIGITAL;
		end else begin
			iface = IF_ANALOG;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			active_iface_o     <= IF_NONE;
			analog_power_o     <= 1'b0;
			digital_power_o    <= 1'b0;
			hsync_det_power_o  <= 1'b0;
			shared_power_o     <= 1'b0;
			sync_present_pin_o <= 1'b0;
		end else begin
			active_iface_o <= iface;
			// RULE_07: Only active side fully powered
			analog_power_o  <= (iface == IF_ANALOG);
			digital_power_o <= (iface == IF_DIGITAL);
			// RULE_08: Hsync detect kept on digital
			hsync_det_power_o <= (iface != IF_NONE);
			// RULE_09: Shared blocks on when active
			shared_power_o <= (iface != IF_NONE);
			// RULE_02: Sync pin low when down
			if (iface == IF_DIGITAL) begin
				sync_present_pin_o <= dclk_f;
			end else if (iface == IF_ANALOG) begin
				sync_present_pin_o <= ana_det;
			end else begin
				sync_present_pin_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- verilog/sel_power_controller.sv
// Controller end: AXI4-Lite registers, polling policy, serial master
`include "sel_power_defs.svh"
`default_nettype none
module sel_power_controller #(
	parameter int HALF_CYC = `SER_HALF_CYC,
	parameter int POLL_CYC = `POLL_CYC,
	parameter int HPD_CYC  = `HPD_CYC
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	serial_reg_if.ctrl       bus,
	input  wire logic        digital_detect_i,
	output logic             hotplug_o,
	output logic             irq_o
);
	import sel_power_pkg::*;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [1:0] s1_q, s2_q, s3_q, f_q, agr;
	assign agr = ~(s2_q ^ s3_q);
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= 2'h1;
			s2_q <= 2'h1;
			s3_q <= 2'h1;
			f_q  <= 2'h1;
		end else begin
			s1_q <= {digital_detect_i, bus.sda};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q  <= (f_q & ~agr) | (s3_q & agr);
		end
	end

	////////////////////////////////////////////////////////////////
	// Serial master

	ser_state_t  st_q;
	logic [15:0] div_q;
	logic        tick;
	logic [16:0] fr_q;
	logic [4:0]  bit_q;
	logic [7:0]  rx_q;
	logic        scl_q, oe_q, done_q;
	logic        req_q, req_rd_q;
	logic [7:0]  req_addr_q, req_data_q;

	assign tick = (div_q == 16'h0000);
	assign bus.scl = scl_q;
	assign bus.sda_m_oe = oe_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_q <= 16'h0000;
		end else if (st_q == S_IDLE || tick) begin
			div_q <= 16'(HALF_CYC - 1);
		end else begin
			div_q <= div_q - 16'h0001;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= S_IDLE;
			scl_q <= 1'b1;
			oe_q <= 1'b0;
			done_q <= 1'b0;
			fr_q <= 17'h00000;
			bit_q <= 5'h00;
			rx_q <= 8'h00;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				S_IDLE: begin
					if (req_q) begin
						fr_q <= {req_rd_q, req_addr_q, req_data_q};
						bit_q <= 5'h00;
						oe_q <= 1'b1;
						st_q <= S_START;
					end
				end
				S_START: begin
					if (tick) begin
						scl_q <= 1'b0;
						oe_q <= ~fr_q[16];
						st_q <= S_LOW;
					end
				end
				S_LOW: begin
					if (tick) begin
						scl_q <= 1'b1;
						st_q <= S_HIGH;
					end
				end
				S_HIGH: begin
					if (tick) begin
						rx_q <= {rx_q[6:0], f_q[0]};
						fr_q <= {fr_q[15:0], 1'b0};
						bit_q <= bit_q + 5'h01;
						scl_q <= 1'b0;
						if (bit_q == `LAST_BIT) begin
							oe_q <= 1'b1;
							st_q <= S_P1;
						end else begin
							oe_q <= (~req_rd_q
								| (bit_q < `ADDR_DONE_BIT))
								& ~fr_q[15];
							st_q <= S_LOW;
						end
					end
				end
				S_P1: begin
					if (tick) begin
						scl_q <= 1'b1;
						st_q <= S_P2;
					end
				end
				S_P2: begin
					if (tick) begin
						oe_q <= 1'b0;
						st_q <= S_P3;
					end
				end
				default: begin
					if (tick) begin
						done_q <= 1'b1;
						st_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Selection policy

	ctl_state_t  cs_q;
	logic [15:0] poll_q;
	logic [7:0]  stat_q, wr_q, want;
	logic        wr_ok_q;
	logic [2:0]  cfg_q;
	logic [1:0]  int_q, mask_q;
	logic [15:0] hpd_q;
	logic        ana, dig, choice;

	// RULE_03: Analog activity is OR of 7:5
	assign ana = |rx_q[`STAT_ANA_HI:`STAT_ANA_LO];
	// RULE_05: Digital activity from external detector
	assign dig = f_q[1];
	// RULE_06: Priority from preference bit
	assign choice = (ana & dig) ? cfg_q[`C_PREF_BIT] : dig;

	always_comb begin
		want = 8'h00;
		// RULE_11: Power down when nothing active
		if (ana | dig) begin
			// RULE_04: Override set, explicit choice
			want[`CTRL_OVR_BIT] = 1'b1;
			want[`CTRL_CHOICE_BIT] = choice;
			want[`CTRL_PWR_BIT] = 1'b1;
		end
	end

	logic wr_evt;
	assign wr_evt = (cs_q == C_WRITE) & done_q;

	// RULE_13: Status read then control write
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_q <= C_WAIT;
			poll_q <= 16'h0000;
			req_q <= 1'b0;
			req_rd_q <= 1'b0;
			req_addr_q <= 8'h00;
			req_data_q <= 8'h00;
			stat_q <= 8'h00;
			wr_q <= `DEV_CTRL_RST;
			wr_ok_q <= 1'b0;
		end else begin
			req_q <= 1'b0;
			case (cs_q)
				C_WAIT: begin
					if (poll_q != 16'h0000) begin
						poll_q <= poll_q - 16'h0001;
					end else if (cfg_q[`C_AUTO_BIT]) begin
						req_q <= 1'b1;
						req_rd_q <= 1'b1;
						req_addr_q <= `DEV_STATUS_ADDR;
						cs_q <= C_READ;
					end
				end
				C_READ: begin
					if (done_q) begin
						stat_q <= rx_q;
						if (!wr_ok_q || want != wr_q) begin
							req_q <= 1'b1;
							req_rd_q <= 1'b0;
							req_addr_q <= `DEV_CTRL_ADDR;
							req_data_q <= want;
							cs_q <= C_WRITE;
						end else begin
							poll_q <= 16'(POLL_CYC);
							cs_q <= C_WAIT;
						end
					end
				end
				default: begin
					if (done_q) begin
						wr_q <= req_data_q;
						wr_ok_q <= 1'b1;
						poll_q <= 16'(POLL_CYC);
						cs_q <= C_WAIT;
					end
				end
			endcase
		end
	end

	// RULE_12: Hot-plug pulse on analog to digital
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hpd_q <= 16'h0000;
			hotplug_o <= 1'b0;
		end else begin
			if (wr_evt && cfg_q[`C_HPEN_BIT] && wr_ok_q
				&& wr_q[`CTRL_PWR_BIT] && !wr_q[`CTRL_CHOICE_BIT]
				&& req_data_q[`CTRL_PWR_BIT]
				&& req_data_q[`CTRL_CHOICE_BIT]) begin
				hpd_q <= 16'(HPD_CYC);
			end else if (hpd_q != 16'h0000) begin
				hpd_q <= hpd_q - 16'h0001;
			end
			hotplug_o <= (hpd_q > 16'h0001) || (wr_evt && hpd_q == 16'h0000
				&& cfg_q[`C_HPEN_BIT] && wr_ok_q && wr_q[`CTRL_PWR_BIT]
				&& !wr_q[`CTRL_CHOICE_BIT] && req_data_q[`CTRL_CHOICE_BIT]
				&& req_data_q[`CTRL_PWR_BIT]);
		end
	end

	////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	logic        aw_q, w_q;
	logic [4:0]  awa_q;
	logic [31:0] wd_q;
	logic        ws_q;
	logic        do_wr;
	logic [1:0]  evt, clr;

	assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_wr = aw_q & w_q & ~s_axi_bvalid;
	assign evt = {wr_evt & ~req_data_q[`CTRL_PWR_BIT], wr_evt};
	assign clr = (do_wr && ws_q && awa_q == `C_INT_OFS) ? wd_q[1:0] : 2'h0;
	assign irq_o = |(int_q & mask_q);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 5'h00;
			wd_q <= 32'h00000000;
			ws_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			cfg_q <= `C_CTRL_RST;
			mask_q <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awa_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (awa_q == `C_CTRL_OFS) begin
					if (ws_q) cfg_q <= wd_q[2:0];
				end else if (awa_q == `C_MASK_OFS) begin
					if (ws_q) mask_q <= wd_q[1:0];
				end else if (awa_q != `C_INT_OFS) begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Set wins over write-one clear
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_q <= 2'h0;
		end else begin
			int_q <= (int_q & ~clr) | evt;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			if (s_axi_araddr == `C_CTRL_OFS) begin
				s_axi_rdata <= {29'h0, cfg_q};
			end else if (s_axi_araddr == `C_STAT_OFS) begin
				s_axi_rdata <= {13'h0, wr_ok_q, st_q != S_IDLE,
					dig, wr_q, stat_q};
			end else if (s_axi_araddr == `C_INT_OFS) begin
				s_axi_rdata <= {30'h0, int_q};
			end else if (s_axi_araddr == `C_MASK_OFS) begin
				s_axi_rdata <= {30'h0, mask_q};
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- verif/sel_power_monitor.sv
// Checker for the serial link and the device power outputs
`default_nettype none
module sel_power_monitor (
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  scl,
	input  wire logic                  sda,
	input  wire logic [7:0]            ctrl_reg_o,
	input  var  sel_power_pkg::iface_t active_iface_o,
	input  wire logic                  analog_power_o,
	input  wire logic                  digital_power_o,
	input  wire logic                  hsync_det_power_o,
	input  wire logic                  shared_power_o,
	input  wire logic                  sync_present_pin_o
);
	import sel_power_pkg::*;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////
	a_override_pick: assert property (
		$stable(ctrl_reg_o) && ctrl_reg_o[7] && ctrl_reg_o[0] |->
		active_iface_o == (ctrl_reg_o[6] ? IF_DIGITAL : IF_ANALOG))
		else $error("override choice not applied");
	a_power_down: assert property (
		$stable(ctrl_reg_o) && !ctrl_reg_o[0] |->
		active_iface_o == IF_NONE && !analog_power_o &&
		!digital_power_o && !sync_present_pin_o)
		else $error("power-down not applied");
	a_sync_gated: assert property (
		sync_present_pin_o |-> active_iface_o != IF_NONE)
		else $error("sync pin high while powered down");
	a_analog_side: assert property (
		active_iface_o == IF_ANALOG |-> analog_power_o && !digital_power_o)
		else $error("digital side powered while analog active");
	a_digital_side: assert property (
		active_iface_o == IF_DIGITAL |->
		digital_power_o && !analog_power_o && hsync_det_power_o)
		else $error("wrong power while digital active");
	a_shared_kept: assert property (
		active_iface_o != IF_NONE |-> shared_power_o)
		else $error("shared logic off while active");
	a_setting_holds: assert property (
		scl [*8] ##1 scl |-> $stable(ctrl_reg_o))
		else $error("setting changed with no frame");
	a_write_in_high: assert property (
		$changed(ctrl_reg_o) |-> scl && $past(scl))
		else $error("setting changed outside a clock-high phase");
	c_analog: cover property (active_iface_o == IF_ANALOG);
	c_digital: cover property (active_iface_o == IF_DIGITAL);
	c_start: cover property ($fell(sda) && scl);
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench: controller and device joined by the serial link
`include "sel_power_defs.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import sel_power_pkg::*;
	localparam int HPD = 10;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [2:0]  ana;
	logic        dclk, ddet, hotplug, irq, ap, dp, hp, sp, sync;
	logic [7:0]  ctrl;
	iface_t      iface;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          hp_len = 0;
	logic [65:0] rd_q[$];
	logic [1:0]  wr_q[$];
	int          hp_q[$];
	logic [2:0]  tbl[5] = '{3'b100, 3'b010, 3'b110, 3'b111, 3'b000};
	serial_reg_if link();
	sel_power_controller #(.HALF_CYC(8), .POLL_CYC(20), .HPD_CYC(HPD))
	sel_power_controller_inst (.core_clk_i(clk), .rst_n_i(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .bus(link), .digital_detect_i(ddet),
		.hotplug_o(hotplug), .irq_o(irq));
	sel_power_device sel_power_device_inst (.core_clk_i(clk),
		.rst_n_i(rst_n), .bus(link), .analog_act_i(ana),
		.digital_clk_det_i(dclk), .active_iface_o(iface),
		.analog_power_o(ap), .digital_power_o(dp), .hsync_det_power_o(hp),
		.shared_power_o(sp), .sync_present_pin_o(sync), .ctrl_reg_o(ctrl));
	sel_power_monitor sel_power_monitor_inst (.core_clk_i(clk),
		.rst_n_i(rst_n), .scl(link.scl), .sda(link.sda),
		.ctrl_reg_o(ctrl), .active_iface_o(iface), .analog_power_o(ap),
		.digital_power_o(dp), .hsync_det_power_o(hp), .shared_power_o(sp),
		.sync_present_pin_o(sync));
	always #20 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
			input logic [1:0] r);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		wr_q.push_back(r);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge clk);
			if (awvalid && awready) ta = 1'b1;
			if (wvalid && wready) tw = 1'b1;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		do @(negedge clk); while (!bvalid);
		@(posedge clk);
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic axi_rd(input logic [4:0] a, input logic [31:0] e, m,
			input logic [1:0] r);
		rd_q.push_back({r, m, e & m});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		@(posedge clk);
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic settle(input logic [7:0] rg, input logic [6:0] st);
		int n;
		for (n = 0; n < 4000 && ctrl !== rg; n++) @(posedge clk);
		// Let a fresh status poll land
		repeat (400) @(posedge clk);
		chk("ctrl", 32'(rg), 32'(ctrl));
		chk("power", 32'(st), 32'({iface, ap, dp, hp, sp, sync}));
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (rvalid && rready && rd_q.size() != 0) begin
			chk("rdata", rd_q[0][31:0], rdata & rd_q[0][63:32]);
			chk("rresp", 32'(rd_q[0][65:64]), 32'(rresp));
			void'(rd_q.pop_front());
		end
		if (bvalid && bready && wr_q.size() != 0)
			chk("bresp", 32'(wr_q.pop_front()), 32'(bresp));
		if (hotplug)
			hp_len <= hp_len + 1;
		else if (hp_len != 0) begin
			chk("hotplug", hp_q.size() ? hp_q.pop_front() : 0, hp_len);
			hp_len <= 0;
		end
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			give_verdict();
		end
	end
	initial begin
		int i, n;
		logic [2:0] a;
		logic d, c;
		iface_t prev, nx;
		logic [7:0] rg;
		logic [6:0] st;
		void'($urandom(32'h672b3ccb));
		{awaddr, araddr, wdata, wstrb, ana, dclk, ddet, awvalid, wvalid,
			bready, arvalid, rready} <= '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		axi_rd(`C_CTRL_OFS, 32'h5, '1, `RESP_OKAY);
		axi_rd(`C_MASK_OFS, 32'h0, '1, `RESP_OKAY);
		axi_rd(5'h10, 32'h0, '1, `RESP_SLVERR);
		axi_wr(5'h14, '1, `RESP_SLVERR);
		axi_wr(`C_MASK_OFS, 32'h2, `RESP_OKAY);
		for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clk);
		axi_rd(`C_INT_OFS, 32'h3, 32'h3, `RESP_OKAY);
		axi_wr(`C_MASK_OFS, 32'h0, `RESP_OKAY);
		@(negedge clk);
		chk("irq", 32'h0, 32'(irq));
		axi_wr(`C_INT_OFS, 32'h2, `RESP_OKAY);
		axi_rd(`C_INT_OFS, 32'h1, 32'h3, `RESP_OKAY);
		axi_wr(`C_MASK_OFS, 32'h3, `RESP_OKAY);
		settle(8'h00, {IF_NONE, 5'b0});
		prev = IF_NONE;
		for (i = 0; i < 5; i++) begin
			a = tbl[i][2] ? 3'($urandom_range(7, 1)) : 3'b0;
			d = tbl[i][1];
			c = 1'($urandom);
			axi_wr(`C_CTRL_OFS, {29'h0, 1'b1, tbl[i][0], 1'b1}, `RESP_OKAY);
			ana <= a;
			ddet <= d;
			dclk <= c;
			nx = (a == 0 && !d) ? IF_NONE :
				(d && (a == 0 || tbl[i][0])) ? IF_DIGITAL : IF_ANALOG;
			rg = (nx == IF_NONE) ? 8'h00 : (nx == IF_DIGITAL) ? 8'hc1 : 8'h81;
			st = (nx == IF_NONE) ? {IF_NONE, 5'b0} : (nx == IF_DIGITAL) ?
				{IF_DIGITAL, 4'b0111, c} : {IF_ANALOG, 5'b10111};
			if (prev == IF_ANALOG && nx == IF_DIGITAL) hp_q.push_back(HPD);
			settle(rg, st);
			axi_rd(`C_STAT_OFS, {15'h0, d, rg, a, c, 4'h0}, 32'h1fff0,
				`RESP_OKAY);
			prev = nx;
		end
		axi_rd(`C_INT_OFS, 32'h3, 32'h3, `RESP_OKAY);
		@(negedge clk);
		chk("irq", 32'h1, 32'(irq));
		repeat (2 * HPD) @(posedge clk);
		chk("hotplug pending", 32'h0, 32'(hp_q.size()));
		give_verdict();
	end
endmodule
`default_nettype wire
